// ---- tccu_pkg.sv ----
package tccu_pkg;

  // Bus geometry
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 32;

  // Register indices; the byte address is four times the index
  localparam logic [7:0]  IDX_PORT        = 8'hC0;
  localparam logic [7:0]  IDX_FLAGS       = 8'hC8;
  localparam logic [7:0]  IDX_SET_VAL     = 8'hD0;
  localparam logic [7:0]  IDX_CLEAR_VAL   = 8'hD1;
  localparam logic [7:0]  IDX_FLIP_VAL    = 8'hD2;
  localparam logic [7:0]  IDX_CAPTURE_A   = 8'hD4;
  localparam logic [7:0]  IDX_CAPTURE_B   = 8'hD5;
  localparam logic [7:0]  IDX_CAPTURE_C   = 8'hD6;
  localparam logic [7:0]  IDX_CAPTURE_D   = 8'hD7;
  localparam logic [7:0]  IDX_BYTE_OVF    = 8'hEA;
  localparam logic [7:0]  IDX_EDGE        = 8'hEB;
  localparam logic [7:0]  IDX_SET_EN      = 8'hEE;
  localparam logic [7:0]  IDX_CLR_FLIP_EN = 8'hEF;
  localparam logic [7:0]  IDX_PRIORITY    = 8'hF8;

  // Reset values
  localparam logic [7:0]  RST_PORT        = 8'h00;
  localparam logic [7:0]  RST_FLAGS       = 8'h00;
  localparam logic [7:0]  RST_EDGE        = 8'h00;
  localparam logic [7:0]  RST_SET_EN      = 8'hC0;
  localparam logic [7:0]  RST_CLR_FLIP_EN = 8'h00;
  localparam logic [7:0]  RST_PRIORITY    = 8'h00;
  localparam logic [15:0] RST_COMPARE     = 16'h0000;
  localparam logic [15:0] RST_CAPTURE     = 16'h0000;

  // Flag register fields
  localparam int          FLAG_WIDE_OVF   = 7;
  localparam int          FLAG_MATCH_C    = 6;
  localparam int          FLAG_MATCH_B    = 5;
  localparam int          FLAG_MATCH_A    = 4;
  localparam int          FLAG_CAPTURE_D  = 3;
  localparam int          FLAG_CAPTURE_C  = 2;
  localparam int          FLAG_CAPTURE_B  = 1;
  localparam int          FLAG_CAPTURE_A  = 0;
  localparam int          BYTE_OVF_BIT    = 4;

  // Port field split
  localparam int          SET_BITS        = 6;
  localparam int          FLIP_LO         = 6;

  // Machine cycle: six states, one clock each
  typedef enum logic [5:0] {
    TCCU_S1 = 6'h01,
    TCCU_S2 = 6'h02,
    TCCU_S3 = 6'h04,
    TCCU_S4 = 6'h08,
    TCCU_S5 = 6'h10,
    TCCU_S6 = 6'h20
  } tccu_phase_t;

endpackage

// ---- tccu_top.sv ----
// Function
// (R1) Selected capture edge copies timer value into channel register and raises its flag.
// (R2) Each capture channel has a falling-enable and rising-enable bit; both gives either edge.
// (R3) Capture inputs sampled once per machine cycle; timer latched at that cycle's end.
// (R4) Every timer increment compares new value with all three compare registers.
// (R5) First compare match sets port bits 0-5 whose set-enable bit is one.
// (R6) Second compare match clears port bits 0-5 whose clear-enable bit is one.
// (R7) Third compare match toggles port bits 6 and 7 via last-operation flip-flops.
// (R8) Toggle alternates from stored last operation, regardless of software port writes.
// (R9) After reset the first toggle of each toggled bit sets the port latch.
// (R10) Toggle flip-flops read back read-only in set-enable bits 7 and 6.
// (R11) All three compare registers reset to zero.
// (R12) Match changes pins at S5 of next cycle; software writes at next S1.
// (R13) Hardware compare change beats software change to the same bit in one cycle.
// (R14) Simultaneous set and clear demands on one port bit leave it cleared.
// (R15) Capture flags 0,1 set at S4; flags 2,3 set at S6 of capture cycle.
// (R16) Compare flags set at S6 of the cycle after the match.
// (R17) Wide and byte overflow flags set at S6 of the overflow cycle.
// (R18) Nine flags: eight in flag register, byte overflow in its own register.
// (R19) Each priority bit set means high priority, cleared means low priority.
// (R20) Software clears flags itself; hardware never clears them on service.
`timescale 1ns/1ps
`default_nettype none

module tccu_top
  import tccu_pkg::*;
(
  input  wire logic              pclk,                // Bus and state clock
  input  wire logic              presetn,             // Async reset, active low
  input  wire logic              psel,                // APB select
  input  wire logic              penable,             // APB access phase
  input  wire logic              pwrite,              // APB direction
  input  wire logic [ADDR_W-1:0] paddr,               // APB byte address
  input  wire logic [DATA_W-1:0] pwdata,              // APB write data
  output var  logic [DATA_W-1:0] prdata,              // APB read data
  output var  logic              pready,              // APB ready
  output var  logic              pslverr,             // APB error on unmapped
  input  wire logic [15:0]       free_running_timer,  // Current timer value
  input  wire logic              timer_tick,          // Timer incremented, pulse
  input  wire logic              byte_overflow_in,    // Low byte overflow, pulse
  input  wire logic              wide_overflow_in,    // 16-bit overflow, pulse
  input  wire logic              capture_a_input,     // Capture event input A
  input  wire logic              capture_b_input,     // Capture event input B
  input  wire logic              capture_c_input,     // Capture event input C
  input  wire logic              capture_d_input,     // Capture event input D
  output var  logic [7:0]        port_pins,           // Driven output port
  output var  logic [7:0]        timer_flag_bits,     // Eight interrupt flags
  output var  logic              byte_overflow_flag,  // Ninth interrupt flag
  output var  logic [7:0]        timer_priority_bits, // Per-source priority
  output var  logic [5:0]        machine_state        // One-hot S1..S6
);

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    addr_is = (a[ADDR_W-1:2] == {2'h0, idx});
  endfunction

  // Rising- and falling-enable pair for one channel
  function automatic logic edge_hit(input logic prev, input logic now, input logic [1:0] sel);
    edge_hit = (sel[0] & ~prev & now) | (sel[1] & prev & ~now);
  endfunction

  tccu_phase_t phase;

  logic [7:0]  capture_edge_select;
  logic [5:0]  set_enable_bits;
  logic [1:0]  flip_state;
  logic [7:0]  clear_flip_enable_bits;
  logic [15:0] compare_set_value;
  logic [15:0] compare_clear_value;
  logic [15:0] compare_flip_value;
  logic [15:0] capture_reg [4];
  logic [3:0]  cap_in;
  logic [3:0]  cap_sample;
  logic [3:0]  cap_hit;
  logic [3:0]  next_cap_hit;
  logic [2:0]  match_cur;
  logic [2:0]  match_prev;
  logic [2:0]  next_match_cur;
  logic [1:0]  ovf_pend;
  logic [1:0]  next_ovf_pend;
  logic [7:0]  sw_mask;
  logic [7:0]  sw_data;
  logic [7:0]  hw_set;
  logic [7:0]  hw_clr;
  logic [1:0]  hw_flip;
  logic [7:0]  hw_touch;
  logic [7:0]  flag_set;
  logic        byte_set;
  logic        access;
  logic        wr_fire;
  logic        rd_take;
  logic        addr_hit;
  logic [7:0]  rd_byte;
  logic [15:0] rd_word;

  assign cap_in  = {capture_d_input, capture_c_input, capture_b_input, capture_a_input};
  assign access  = psel & penable;
  assign wr_fire = access & pready & pwrite;
  assign rd_take = access & ~pready;

  // Machine cycle sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= TCCU_S1;
    end else begin
      case (phase)
        TCCU_S1: phase <= TCCU_S2;
        TCCU_S2: phase <= TCCU_S3;
        TCCU_S3: phase <= TCCU_S4;
        TCCU_S4: phase <= TCCU_S5;
        TCCU_S5: phase <= TCCU_S6;
        TCCU_S6: phase <= TCCU_S1;
        default: phase <= TCCU_S1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      machine_state <= TCCU_S1;
    end else begin
      case (phase)
        TCCU_S1: machine_state <= TCCU_S2;
        TCCU_S2: machine_state <= TCCU_S3;
        TCCU_S3: machine_state <= TCCU_S4;
        TCCU_S4: machine_state <= TCCU_S5;
        TCCU_S5: machine_state <= TCCU_S6;
        TCCU_S6: machine_state <= TCCU_S1;
        default: machine_state <= TCCU_S1;
      endcase
    end
  end

  // Capture edge detection, one sample per machine cycle
  always_comb begin
    next_cap_hit = cap_hit;
    for (int i = 0; i < 4; i++) begin
      next_cap_hit[i] = edge_hit(cap_sample[i], cap_in[i], capture_edge_select[2*i +: 2]); // R2
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_sample <= 4'h0;
      cap_hit    <= 4'h0;
    end else if (phase == TCCU_S1) begin
      cap_sample <= cap_in;       // R3
      cap_hit    <= next_cap_hit; // R3
    end else if (phase == TCCU_S6) begin
      cap_hit    <= 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        capture_reg[i] <= RST_CAPTURE;
      end
    end else if (phase == TCCU_S6) begin
      for (int i = 0; i < 4; i++) begin
        if (cap_hit[i]) begin
          capture_reg[i] <= free_running_timer; // R1 R3
        end
      end
    end
  end

  // Compare on each increment; result carried into the next cycle
  always_comb begin
    next_match_cur = match_cur;
    if (timer_tick) begin
      next_match_cur[0] = match_cur[0] | (free_running_timer == compare_set_value);   // R4
      next_match_cur[1] = match_cur[1] | (free_running_timer == compare_clear_value); // R4
      next_match_cur[2] = match_cur[2] | (free_running_timer == compare_flip_value);  // R4
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_cur  <= 3'h0;
      match_prev <= 3'h0;
    end else if (phase == TCCU_S6) begin
      match_prev <= next_match_cur;
      match_cur  <= 3'h0;
    end else begin
      match_cur  <= next_match_cur;
    end
  end

  always_comb begin
    next_ovf_pend = ovf_pend | {wide_overflow_in, byte_overflow_in};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_pend <= 2'h0;
    end else if (phase == TCCU_S6) begin
      ovf_pend <= 2'h0;
    end else begin
      ovf_pend <= next_ovf_pend;
    end
  end

  // Hardware port changes from the previous cycle's matches
  always_comb begin
    hw_set  = 8'h00;
    hw_clr  = 8'h00;
    hw_flip = 2'h0;
    if (match_prev[0]) begin
      hw_set[SET_BITS-1:0] = set_enable_bits; // R5
    end
    if (match_prev[1]) begin
      hw_clr[SET_BITS-1:0] = clear_flip_enable_bits[SET_BITS-1:0]; // R6
    end
    if (match_prev[2]) begin
      hw_flip = clear_flip_enable_bits[7:FLIP_LO]; // R7
    end
    hw_touch = (hw_set | hw_clr) | {hw_flip, 6'h00};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_pins  <= RST_PORT;
      flip_state <= 2'h3; // R9
    end else if (phase == TCCU_S5) begin
      port_pins[SET_BITS-1:0] <= (port_pins[SET_BITS-1:0] | hw_set[SET_BITS-1:0])
                                 & ~hw_clr[SET_BITS-1:0]; // R12 R14
      for (int b = 0; b < 2; b++) begin
        if (hw_flip[b]) begin
          port_pins[FLIP_LO+b] <= flip_state[b]; // R7 R8
        end
      end
      flip_state <= flip_state ^ hw_flip; // R8
    end else if (phase == TCCU_S1) begin
      port_pins <= (port_pins & ~sw_mask) | (sw_data & sw_mask); // R12
    end
  end

  // Software port write waits for the next S1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_mask <= 8'h00;
      sw_data <= 8'h00;
    end else if (wr_fire && addr_is(paddr, IDX_PORT)) begin
      sw_data <= pwdata[7:0];
      sw_mask <= (phase == TCCU_S5) ? ~hw_touch : 8'hFF; // R13
    end else if (phase == TCCU_S5) begin
      sw_mask <= sw_mask & ~hw_touch; // R13
    end else if (phase == TCCU_S1) begin
      sw_mask <= 8'h00;
    end
  end

  // Flag setting; a hardware set wins over a software clear
  always_comb begin
    flag_set = 8'h00;
    byte_set = 1'b0;
    if (phase == TCCU_S4) begin
      flag_set[FLAG_CAPTURE_A] = cap_hit[0]; // R1 R15
      flag_set[FLAG_CAPTURE_B] = cap_hit[1]; // R15
    end
    if (phase == TCCU_S6) begin
      flag_set[FLAG_CAPTURE_C] = cap_hit[2];    // R15
      flag_set[FLAG_CAPTURE_D] = cap_hit[3];    // R15
      flag_set[FLAG_MATCH_A]   = match_prev[0]; // R16
      flag_set[FLAG_MATCH_B]   = match_prev[1]; // R16
      flag_set[FLAG_MATCH_C]   = match_prev[2]; // R16
      flag_set[FLAG_WIDE_OVF]  = next_ovf_pend[1]; // R17
      byte_set = next_ovf_pend[0] | next_ovf_pend[1]; // R17
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_flag_bits <= RST_FLAGS;
    end else if (wr_fire && addr_is(paddr, IDX_FLAGS)) begin
      timer_flag_bits <= pwdata[7:0] | flag_set; // R18 R20
    end else begin
      timer_flag_bits <= timer_flag_bits | flag_set; // R20
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_overflow_flag <= 1'b0;
    end else if (wr_fire && addr_is(paddr, IDX_BYTE_OVF)) begin
      byte_overflow_flag <= pwdata[BYTE_OVF_BIT] | byte_set; // R18 R20
    end else begin
      byte_overflow_flag <= byte_overflow_flag | byte_set; // R18
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_edge_select    <= RST_EDGE;
      set_enable_bits        <= RST_SET_EN[SET_BITS-1:0];
      clear_flip_enable_bits <= RST_CLR_FLIP_EN;
      timer_priority_bits    <= RST_PRIORITY;
    end else if (wr_fire) begin
      if (addr_is(paddr, IDX_EDGE)) begin
        capture_edge_select <= pwdata[7:0];
      end
      if (addr_is(paddr, IDX_SET_EN)) begin
        set_enable_bits <= pwdata[SET_BITS-1:0];
      end
      if (addr_is(paddr, IDX_CLR_FLIP_EN)) begin
        clear_flip_enable_bits <= pwdata[7:0];
      end
      if (addr_is(paddr, IDX_PRIORITY)) begin
        timer_priority_bits <= pwdata[7:0]; // R19
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_set_value   <= RST_COMPARE; // R11
      compare_clear_value <= RST_COMPARE; // R11
      compare_flip_value  <= RST_COMPARE; // R11
    end else if (wr_fire) begin
      if (addr_is(paddr, IDX_SET_VAL)) begin
        compare_set_value <= pwdata[15:0];
      end
      if (addr_is(paddr, IDX_CLEAR_VAL)) begin
        compare_clear_value <= pwdata[15:0];
      end
      if (addr_is(paddr, IDX_FLIP_VAL)) begin
        compare_flip_value <= pwdata[15:0];
      end
    end
  end

  // Read multiplexer
  always_comb begin
    rd_byte  = 8'h00;
    rd_word  = 16'h0000;
    addr_hit = 1'b1;
    if (addr_is(paddr, IDX_PORT)) begin
      rd_byte = port_pins;
    end else if (addr_is(paddr, IDX_FLAGS)) begin
      rd_byte = timer_flag_bits;
    end else if (addr_is(paddr, IDX_BYTE_OVF)) begin
      rd_byte[BYTE_OVF_BIT] = byte_overflow_flag;
    end else if (addr_is(paddr, IDX_EDGE)) begin
      rd_byte = capture_edge_select;
    end else if (addr_is(paddr, IDX_SET_EN)) begin
      rd_byte = {flip_state, set_enable_bits}; // R10
    end else if (addr_is(paddr, IDX_CLR_FLIP_EN)) begin
      rd_byte = clear_flip_enable_bits;
    end else if (addr_is(paddr, IDX_PRIORITY)) begin
      rd_byte = timer_priority_bits;
    end else if (addr_is(paddr, IDX_SET_VAL)) begin
      rd_word = compare_set_value;
    end else if (addr_is(paddr, IDX_CLEAR_VAL)) begin
      rd_word = compare_clear_value;
    end else if (addr_is(paddr, IDX_FLIP_VAL)) begin
      rd_word = compare_flip_value;
    end else if (addr_is(paddr, IDX_CAPTURE_A)) begin
      rd_word = capture_reg[0];
    end else if (addr_is(paddr, IDX_CAPTURE_B)) begin
      rd_word = capture_reg[1];
    end else if (addr_is(paddr, IDX_CAPTURE_C)) begin
      rd_word = capture_reg[2];
    end else if (addr_is(paddr, IDX_CAPTURE_D)) begin
      rd_word = capture_reg[3];
    end else begin
      addr_hit = 1'b0;
    end
  end

  // APB slave: one wait state in every access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready <= rd_take;
      if (rd_take) begin
        pslverr <= ~addr_hit;
        prdata  <= pwrite ? 32'h0000_0000 : {16'h0000, rd_word | {8'h00, rd_byte}};
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ---- tccu_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module tccu_asserts (
  input wire logic       pclk,                // Clock
  input wire logic       presetn,             // Reset
  input wire logic       psel,                // Select
  input wire logic       penable,             // Access
  input wire logic       pwrite,              // Direction
  input wire logic       pready,              // Ready
  input wire logic [7:0] port_pins,           // Port
  input wire logic [7:0] timer_flag_bits,     // Flags
  input wire logic       byte_overflow_flag,  // Ninth flag
  input wire logic [7:0] timer_priority_bits, // Priority
  input wire logic [5:0] machine_state        // Phase
);
  logic       wr_acc;
  logic       prev_wr;
  logic [7:0] prev_flags;
  logic [7:0] rise;
  assign wr_acc = psel & penable & pready & pwrite;
  assign rise   = timer_flag_bits & ~prev_flags;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_flags <= 8'h00;
      prev_wr    <= 1'b0;
    end else begin
      prev_flags <= timer_flag_bits;
      prev_wr    <= wr_acc;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_phase_walk;
    presetn |=> machine_state == {$past(machine_state[4:0]), $past(machine_state[5])};
  endproperty
  a_phase_walk: assert property (p_phase_walk)
    else $error("machine state did not rotate");
  property p_port_time;
    $changed(port_pins) |-> machine_state inside {6'h20, 6'h02};
  endproperty
  a_port_time: assert property (p_port_time)
    else $error("port changed outside S5 or S1 edge");
  property p_cap_ab;
    (|rise[1:0]) && !prev_wr |-> machine_state == 6'h10;
  endproperty
  a_cap_ab: assert property (p_cap_ab)
    else $error("capture flag a or b set off S4");
  property p_late_flags;
    (|rise[7:2]) && !prev_wr |-> machine_state == 6'h01;
  endproperty
  a_late_flags: assert property (p_late_flags)
    else $error("late flag set off S6");
  property p_byte_time;
    $rose(byte_overflow_flag) && !prev_wr |-> machine_state == 6'h01;
  endproperty
  a_byte_time: assert property (p_byte_time)
    else $error("byte overflow flag set off S6");
  property p_wide_byte;
    rise[7] && !prev_wr |-> byte_overflow_flag;
  endproperty
  a_wide_byte: assert property (p_wide_byte)
    else $error("wide overflow without byte flag");
  property p_no_auto_clear;
    (prev_flags & ~timer_flag_bits) != 8'h00 |-> prev_wr;
  endproperty
  a_no_auto_clear: assert property (p_no_auto_clear)
    else $error("flag cleared without a write");
  property p_prio_sw;
    $changed(timer_priority_bits) |-> prev_wr;
  endproperty
  a_prio_sw: assert property (p_prio_sw)
    else $error("priority changed without a write");
endmodule
bind tccu_top tccu_asserts tccu_asserts_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .pready, .port_pins, .timer_flag_bits, .byte_overflow_flag, .timer_priority_bits,
  .machine_state);
`default_nettype wire

// ---- tccu_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module tccu_partner (
  input  wire logic        pclk,     // Clock
  input  wire logic        presetn,  // Reset
  input  wire logic        run,      // Count enable
  input  wire logic        load,     // Preset strobe
  input  wire logic [15:0] load_val, // Preset value
  input  wire logic [3:0]  events,   // Wanted event levels
  output var  logic [15:0] count,    // Timer value
  output var  logic        tick,     // Increment pulse
  output var  logic        byte_ovf, // Low byte wrap
  output var  logic        wide_ovf, // Full wrap
  output var  logic [3:0]  ev_pins   // Event pins
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count    <= 16'h0000;
      tick     <= 1'b0;
      byte_ovf <= 1'b0;
      wide_ovf <= 1'b0;
      ev_pins  <= 4'h0;
    end else begin
      count    <= load ? load_val : count + {15'h0000, run};
      tick     <= run && !load;
      byte_ovf <= run && !load && count[7:0] == 8'hFF;
      wide_ovf <= run && !load && count == 16'hFFFF;
      ev_pins  <= events;
    end
  end
endmodule
`default_nettype wire

// ---- tccu_top_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module tccu_top_test
  import tccu_pkg::*;
;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic [15:0]       timer;
  logic              tick;
  logic              byte_ovf;
  logic              wide_ovf;
  logic [3:0]        ev_pins;
  logic              run;
  logic              load;
  logic [15:0]       load_val;
  logic [3:0]        events;
  logic [7:0]        port_pins;
  logic [7:0]        flags;
  logic              byte_flag;
  logic [7:0]        prio;
  int                miscompares;
  int                comparisons;
  int                cycles;

  tccu_top tccu_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .free_running_timer(timer), .timer_tick(tick),
    .byte_overflow_in(byte_ovf), .wide_overflow_in(wide_ovf),
    .capture_a_input(ev_pins[0]), .capture_b_input(ev_pins[1]),
    .capture_c_input(ev_pins[2]), .capture_d_input(ev_pins[3]), .port_pins,
    .timer_flag_bits(flags), .byte_overflow_flag(byte_flag),
    .timer_priority_bits(prio), .machine_state());
  tccu_partner tccu_partner_i (.pclk, .presetn, .run, .load, .load_val, .events,
    .count(timer), .tick, .byte_ovf, .wide_ovf, .ev_pins);

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // One APB transfer; the closing idle edge keeps psel low a cycle and lets writes settle
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 32'h0, r, e);
    check(r, exp);
  endtask

  task automatic set_timer(input logic [15:0] v, input logic r);
    @(posedge pclk);
    load     <= 1'b1;
    load_val <= v;
    run      <= 1'b0;
    @(posedge pclk);
    load     <= 1'b0;
    run      <= r;
    repeat (24) @(posedge pclk);
    run      <= 1'b0;
  endtask

  task automatic t_reset();
    logic [7:0] idx [7];
    idx = '{IDX_FLAGS, IDX_SET_VAL, IDX_CLEAR_VAL, IDX_FLIP_VAL, IDX_EDGE,
            IDX_CLR_FLIP_EN, IDX_PRIORITY};
    foreach (idx[i]) rd_chk(idx[i], 32'h0);
    rd_chk(IDX_SET_EN, 32'hC0);
    $display("reset test done");
  endtask

  task automatic t_bus();
    logic [31:0] r;
    logic        e;
    apb(1'b0, 8'h10, 32'h0, r, e);
    check({31'h0, e}, 32'h1);
    wr(IDX_SET_EN, 32'h00);
    rd_chk(IDX_SET_EN, 32'hC0);
    wr(IDX_PRIORITY, 32'hA5);
    check({24'h0, prio}, 32'hA5);
    rd_chk(IDX_PRIORITY, 32'hA5);
    $display("bus test done");
  endtask

  task automatic t_compare();
    wr(IDX_SET_VAL, 32'h0150);
    wr(IDX_CLEAR_VAL, 32'h0150);
    wr(IDX_SET_EN, 32'h3F);
    wr(IDX_CLR_FLIP_EN, 32'h05);
    set_timer(16'h014D, 1'b1);
    check({24'h0, port_pins}, 32'h3A);
    rd_chk(IDX_FLAGS, 32'h30);
    wr(IDX_FLAGS, 32'h0);
    check({24'h0, flags}, 32'h0);
    $display("compare test done");
  endtask

  task automatic t_toggle();
    wr(IDX_FLIP_VAL, 32'h0280);
    wr(IDX_CLR_FLIP_EN, 32'hC0);
    set_timer(16'h027D, 1'b1);
    check({24'h0, port_pins}, 32'hFA);
    rd_chk(IDX_SET_EN, 32'h3F);
    check({24'h0, flags}, 32'h40);
    wr(IDX_PORT, 32'h7A);
    repeat (8) @(posedge pclk);
    check({24'h0, port_pins}, 32'h7A);
    set_timer(16'h027D, 1'b1);
    check({24'h0, port_pins}, 32'h3A);
    rd_chk(IDX_SET_EN, 32'hFF);
    wr(IDX_FLAGS, 32'h0);
    $display("toggle test done");
  endtask

  task automatic t_capture();
    set_timer(16'h1234, 1'b0);
    wr(IDX_EDGE, 32'h79);
    events <= 4'hF;
    repeat (14) @(posedge pclk);
    check({24'h0, flags}, 32'h0D);
    rd_chk(IDX_CAPTURE_A, 32'h1234);
    rd_chk(IDX_CAPTURE_B, 32'h0);
    rd_chk(IDX_CAPTURE_D, 32'h1234);
    set_timer(16'h5678, 1'b0);
    events <= 4'h0;
    repeat (14) @(posedge pclk);
    check({24'h0, flags}, 32'h0F);
    rd_chk(IDX_CAPTURE_B, 32'h5678);
    rd_chk(IDX_CAPTURE_C, 32'h5678);
    rd_chk(IDX_CAPTURE_A, 32'h1234);
    wr(IDX_FLAGS, 32'h0);
    $display("capture test done");
  endtask

  task automatic t_overflow();
    set_timer(16'hFFFD, 1'b1);
    check({24'h0, flags}, 32'h80);
    check({31'h0, byte_flag}, 32'h1);
    rd_chk(IDX_BYTE_OVF, 32'h10);
    wr(IDX_FLAGS, 32'h0);
    wr(IDX_BYTE_OVF, 32'h0);
    check({23'h0, byte_flag, flags}, 32'h0);
    $display("overflow test done");
  endtask

  initial begin
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = '0;
    pwdata      = '0;
    run         = 1'b0;
    load        = 1'b0;
    load_val    = 16'h0000;
    events      = 4'h0;
    miscompares = 0;
    comparisons = 0;
    cycles      = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_bus();
    t_compare();
    t_toggle();
    t_capture();
    t_overflow();
    summarize();
  end
endmodule
`default_nettype wire
